/* dv/board_pins.sv */
// board-side model of the two pins
// assumes the bench sets the board drive; an undriven pin without pull wanders
`timescale 1ns/1ns
module board_pins (
    input wire logic clk_i,
    input wire logic [1:0] drv_en_i,
    input wire logic [1:0] drv_lvl_i,
    input wire logic [1:0] out_i,
    input wire logic [1:0] oe_n_i,
    input wire logic [1:0] pull_up_i,
    input wire logic [1:0] pull_down_i,
    output logic [1:0] level_o
);
    logic [1:0] float_r = 2'b01;
    always_ff @(posedge clk_i)
    begin
        float_r <= ~float_r;
    end
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (!oe_n_i[i])
                level_o[i] = out_i[i];
            else if (drv_en_i[i])
                level_o[i] = drv_lvl_i[i];
            else if (pull_up_i[i] || pull_down_i[i])
                level_o[i] = pull_up_i[i];
            else
                level_o[i] = float_r[i];
        end
    end
endmodule

/* dv/pin_config_assertions.sv */
// port checker for the pin configuration block
// assumes it is bound into pin_config and sees only its ports
`timescale 1ns/1ns
module pin_config_assertions (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [1:0] PIN_OUT_O,
    input wire logic [1:0] PIN_OE_N_O,
    input wire logic [1:0] PIN_PULL_UP_O,
    input wire logic [1:0] PIN_PULL_DOWN_O,
    input wire logic [1:0] PIN_SUPPLY_AON_O,
    input wire logic [1:0] PIN_EDGE_EVT_O,
    input wire logic POWER_TOGGLE_REQ_O,
    input wire logic SLEEP_REQ_O,
    input wire logic [1:0] HW_CONTROL_O
);
    default clocking @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);
    AST_SETUP_ANSWER: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I)
        else $error("error outside access");
    AST_RESET_OFF: assert property ($rose(RST_N_I) |-> PIN_OE_N_O == 2'b11 && PIN_OUT_O == 2'b00)
        else $error("pins driven after reset");
    AST_RESET_PULL: assert property ($rose(RST_N_I) |-> PIN_PULL_DOWN_O == 2'b11 && PIN_PULL_UP_O == 2'b00)
        else $error("pull not down after reset");
    AST_RESET_DOMAIN: assert property ($rose(RST_N_I) |-> PIN_SUPPLY_AON_O == 2'b00)
        else $error("supply domain wrong after reset");
    AST_PULL_EXCL: assert property ((PIN_PULL_UP_O & PIN_PULL_DOWN_O) == 2'b00)
        else $error("pull up and down together");
    AST_EVT_PULSE: assert property (PIN_EDGE_EVT_O[0] |=> !PIN_EDGE_EVT_O[0])
        else $error("edge event too long");
    AST_EVT_UNDRIVEN: assert property (PIN_EDGE_EVT_O != 2'b00 |-> (PIN_OE_N_O & PIN_EDGE_EVT_O) == PIN_EDGE_EVT_O)
        else $error("event on a driven pin");
    AST_OUTPUT_NO_REQ: assert property (PIN_OE_N_O == 2'b00 [*3] |-> !POWER_TOGGLE_REQ_O && !SLEEP_REQ_O && HW_CONTROL_O == 2'b00)
        else $error("request while both pins output");
    cover property (PSLVERR_O);
    cover property (POWER_TOGGLE_REQ_O);
    cover property (PIN_EDGE_EVT_O[0]);
endmodule
bind pin_config pin_config_assertions chk_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PIN_OUT_O(PIN_OUT_O),
    .PIN_OE_N_O(PIN_OE_N_O), .PIN_PULL_UP_O(PIN_PULL_UP_O), .PIN_PULL_DOWN_O(PIN_PULL_DOWN_O),
    .PIN_SUPPLY_AON_O(PIN_SUPPLY_AON_O), .PIN_EDGE_EVT_O(PIN_EDGE_EVT_O),
    .POWER_TOGGLE_REQ_O(POWER_TOGGLE_REQ_O), .SLEEP_REQ_O(SLEEP_REQ_O), .HW_CONTROL_O(HW_CONTROL_O));

/* dv/tb.sv */
// self-checking bench for the pin configuration block
// assumes pin_config, board_pins and the checker are compiled first
`timescale 1ns/1ns
`include "pin_config_defs.svh"
module tb;
    localparam int deb_s = 2;
    localparam int deb_l = 8;
    localparam logic [17:0] a_pin1 = 18'(`PIN1_CONTROL_IDX * 4);
    localparam logic [17:0] a_pin2 = 18'(`PIN2_CONTROL_IDX * 4);
    localparam logic [17:0] a_lvl = 18'(`PIN_LEVEL_IDX * 4);
    localparam int smap [16] = '{-1, -1, 0, 1, 2, -1, -1, -1, 3, 4, 5, 6, 7, 8, -1, 9};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [9:0] src = '0;
    logic [1:0] drv_en = 2'b00;
    logic [1:0] drv_lvl = 2'b00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ptog, swake, sreq, pon, wdog;
    logic [1:0] pin_in, pin_out, oe_n, pu, pd, aon, evt, vsel, hwen, hwctl;
    logic [10:0] req;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    assign req = {hwctl, hwen, vsel, wdog, pon, sreq, swake, ptog};
    always #20 clk = ~clk;
    pin_config #(.DEB_SHORT_CYC(deb_s), .DEB_LONG_CYC(deb_l)) dut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
        .PIN_OE_N_O(oe_n), .PIN_PULL_UP_O(pu), .PIN_PULL_DOWN_O(pd), .PIN_SUPPLY_AON_O(aon),
        .PIN_EDGE_EVT_O(evt), .ON_STATE_I(src[0]), .SLEEP_STATE_I(src[1]), .STATE_CHANGE_I(src[2]),
        .BUCK_DVS_DONE_I(src[4:3]), .EXT_PWR_EN_I(src[6:5]), .SYSTEM_SUPPLY_GOOD_I(src[7]),
        .CONVERTER_POWER_GOOD_I(src[8]), .AUX_RESET_I(src[9]), .POWER_TOGGLE_REQ_O(ptog),
        .SLEEP_WAKE_REQ_O(swake), .SLEEP_REQ_O(sreq), .POWER_ON_REQ_O(pon), .WATCHDOG_KICK_O(wdog),
        .VOLTAGE_SCALE_SELECT_O(vsel), .HW_ENABLE_O(hwen), .HW_CONTROL_O(hwctl));
    board_pins brd (.clk_i(clk), .drv_en_i(drv_en), .drv_lvl_i(drv_lvl), .out_i(pin_out), .oe_n_i(oe_n),
        .pull_up_i(pu), .pull_down_i(pd), .level_o(pin_in));
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask
    // one full transfer, then an idle edge so the next setup never collides
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        chk({oe_n, pu, pd}, 6'b110011);
        chk(aon, 2'b00);
        apb(1'b0, a_pin1, '0);
        chk(rd, 32'h0000a400);
        apb(1'b0, a_pin2, '0);
        chk(rd, 32'h0000a400);
        apb(1'b0, a_pin1 + 18'h8, '0);
        chk({err, rd}, 33'h100000000);
        apb(1'b1, a_pin1 + 18'h1, 32'h0);
        chk(err, 1'b1);
    endtask
    task automatic t_fields();
        apb(1'b1, a_pin2, 32'hffffffff);
        apb(1'b0, a_pin2, '0);
        chk(rd, 32'h0000fe8f);
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, a_pin2, 32'h8800 | (p << 13));
            wt(2);
            chk({pu[1], pd[1], aon[1]}, {p == 2, p == 1, 1'b1});
        end
    endtask
    task automatic t_out();
        apb(1'b1, a_pin1, 32'h0480);
        apb(1'b1, a_pin2, 32'h0480);
        apb(1'b1, a_lvl, 32'h1);
        wt(2);
        chk({oe_n, pin_out}, 4'b0001);
        apb(1'b1, a_pin1, 32'h0080);
        wt(2);
        chk(pin_out[0], 1'b0);
        apb(1'b1, a_pin1, 32'h0680);
        wt(2);
        chk({oe_n[0], pin_out[0]}, 2'b10);
        apb(1'b1, a_lvl, 32'h0);
        wt(2);
        chk({oe_n[0], pin_out[0]}, 2'b00);
        for (int c = 2; c < 16; c++)
        begin
            if (c == 14)
                continue;
            apb(1'b1, a_pin1, 32'h0480 | c);
            src <= smap[c] < 0 ? 10'h3ff : 10'h1 << smap[c];
            wt(3);
            chk(pin_out[0], smap[c] >= 0);
            src <= ~src;
            wt(3);
            chk(pin_out[0], 1'b0);
        end
    endtask
    task automatic t_clocks();
        int half [2] = '{`OSC_SLOW_HALF_CYC, `EXT_CONV_HALF_CYC};
        int t;
        logic last;
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, a_pin1, k == 0 ? 32'h0481 : 32'h048e);
            t = 0;
            last = pin_out[0];
            repeat (half[k] * 8)
            begin
                @(posedge clk);
                t += (pin_out[0] !== last);
                last = pin_out[0];
            end
            chk(t >= 7 && t <= 9, 1'b1);
        end
    endtask
    task automatic t_in();
        int bmap [16] = '{0, 0, 0, 1, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 9, 10};
        drv_en <= 2'b01;
        // settle the filter low first; the clock scenario leaves it at an arbitrary level
        apb(1'b1, a_pin1, 32'h8481);
        wt(deb_s + 2);
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, a_pin1, 32'h8480 | c);
            drv_lvl <= 2'b01;
            wt(deb_s + 3);
            chk(req, (c < 2 || c == 4 || c > 13) ? 11'h0 : 11'h1 << bmap[c]);
            apb(1'b0, a_lvl, '0);
            chk(rd, (c == 0 || c == 4 || c > 13) ? 32'h0 : 32'h10);
            wt(deb_l);
            chk(req, c < 2 ? 11'h0 : 11'h1 << bmap[c]);
            drv_lvl <= 2'b00;
            wt(deb_l + 3);
        end
    endtask
    task automatic t_edges();
        int modes [3] = '{32'h8482, 32'h9482, 32'h8082};
        int n;
        for (int m = 0; m < 3; m++)
        begin
            drv_lvl[0] <= (m == 2);
            wt(deb_s + 4);
            apb(1'b1, a_pin1, modes[m]);
            n = 0;
            for (int t = 0; t < 40; t++)
            begin
                drv_lvl[0] <= ((t >= 10 && t < 25) != (m == 2));
                @(posedge clk);
                n += evt[0];
            end
            chk(n, m == 1 ? 2 : 1);
        end
        chk(req, 11'h0);
    endtask
    task automatic t_block();
        src <= 10'h1;
        apb(1'b1, a_pin1, 32'h0482);
        wt(deb_l + 4);
        chk({pin_out[0], req}, 12'h800);
        drv_lvl <= 2'b01;
        apb(1'b1, a_pin1, 32'h8402);
        wt(deb_l + 4);
        chk({oe_n[0], evt[0], req}, 13'h1000);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        wt(3);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fields();
        t_out();
        t_clocks();
        t_in();
        t_edges();
        t_block();
        complete_run();
    end
endmodule

/* src/pin_config.sv */
// general-purpose pin configuration: two pins, control registers over APB
// assumes synchronous pin inputs, single 25 MHz clock, APB master per AMBA
//
// Contract
// R1 - bit 15 direction, 0 output, reset input
// R2 - pull field: none, down, up; resets down
// R3 - edge mode: one polarity edge or both
// R4 - bit 11 selects pin supply domain
// R5 - bit 10 polarity, 1 active high, reset 1
// R6 - bit 9 open drain versus push-pull
// R7 - bit 7 enable, reset tri-stated
// R8 - function field; codes 0/1 plain input
// R9 - codes 2-6 power and sleep requests
// R10 - code 7 watchdog service input
// R11 - codes 8-11 voltage select, hardware enables
// R12 - codes 12-15 hardware controls, long variants
// R13 - output 0 register level, 1 slow clock
// R14 - outputs 2-4 state indications, 5-7 reserved
// R15 - outputs 8-9 buck voltage change done
// R16 - outputs 10-11 external power enables
// R17 - outputs 12-13 supply good flags
// R18 - output 14 drives 2 MHz clock
// R19 - output 15 drives auxiliary reset
// R20 - direction picks input or output table
// R21 - long variants use longer stability filter
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "pin_config_defs.svh"

module pin_config
    import pin_config_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int DEB_SHORT_CYC = `DEB_SHORT_CYC,
    parameter int DEB_LONG_CYC = `DEB_LONG_CYC
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [1:0] PIN_IN_I,
    output logic [1:0] PIN_OUT_O,
    output logic [1:0] PIN_OE_N_O,
    output logic [1:0] PIN_PULL_UP_O,
    output logic [1:0] PIN_PULL_DOWN_O,
    output logic [1:0] PIN_SUPPLY_AON_O,
    output logic [1:0] PIN_EDGE_EVT_O,
    input wire logic ON_STATE_I,
    input wire logic SLEEP_STATE_I,
    input wire logic STATE_CHANGE_I,
    input wire logic [1:0] BUCK_DVS_DONE_I,
    input wire logic [1:0] EXT_PWR_EN_I,
    input wire logic SYSTEM_SUPPLY_GOOD_I,
    input wire logic CONVERTER_POWER_GOOD_I,
    input wire logic AUX_RESET_I,
    output logic POWER_TOGGLE_REQ_O,
    output logic SLEEP_WAKE_REQ_O,
    output logic SLEEP_REQ_O,
    output logic POWER_ON_REQ_O,
    output logic WATCHDOG_KICK_O,
    output logic [1:0] VOLTAGE_SCALE_SELECT_O,
    output logic [1:0] HW_ENABLE_O,
    output logic [1:0] HW_CONTROL_O
);

    localparam int CNT_W = $clog2(DEB_LONG_CYC + 1);
    localparam int SLOW_W = $clog2(`OSC_SLOW_HALF_CYC + 1);
    localparam int FAST_W = $clog2(`EXT_CONV_HALF_CYC + 1);

    pin_ctl_s ctl_r [2];
    logic [1:0] out_level_r;
    logic [1:0] deb_r;
    logic [1:0] asserted_prev_r;
    logic [15:0] in_hit [2];
    logic [1:0] asserted_c;
    logic [1:0] evt_c;
    logic [1:0] drive_val_c;
    logic [1:0] drive_en_c;

    // ---------------- APB slave ----------------
    logic setup_c;
    logic access_c;
    logic aligned_c;
    logic [ADDR_W-3:0] idx_c;
    logic hit1_c;
    logic hit2_c;
    logic hitl_c;
    logic [31:0] rdata_nxt;

    assign setup_c = PSEL_I & ~PENABLE_I;
    assign access_c = PSEL_I & PENABLE_I & PREADY_O;
    assign aligned_c = (PADDR_I[1:0] == 2'h0);
    assign idx_c = PADDR_I[ADDR_W-1:2];
    assign hit1_c = aligned_c & (idx_c == (ADDR_W-2)'(`PIN1_CONTROL_IDX));
    assign hit2_c = aligned_c & (idx_c == (ADDR_W-2)'(`PIN2_CONTROL_IDX));
    assign hitl_c = aligned_c & (idx_c == (ADDR_W-2)'(`PIN_LEVEL_IDX));

    always_comb
    begin
        rdata_nxt = 32'h0;
        if (hit1_c)
            rdata_nxt = {16'h0, ctl_r[0]};
        else if (hit2_c)
            rdata_nxt = {16'h0, ctl_r[1]};
        else if (hitl_c)
            rdata_nxt = {26'h0, asserted_c, 2'h0, out_level_r};
    end

    // answer comes in the first access cycle, no wait states
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0;
        end
        else
        begin
            PREADY_O <= setup_c;
            PSLVERR_O <= setup_c & ~(hit1_c | hit2_c | hitl_c);
            if (setup_c & ~PWRITE_I)
                PRDATA_O <= rdata_nxt;
            else if (!setup_c)
                PRDATA_O <= 32'h0;
        end
    end

    // control registers; reserved bits are not stored and read zero
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctl_r[0] <= pin_ctl_s'(`PIN_CONTROL_RESET); // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
            ctl_r[1] <= pin_ctl_s'(`PIN_CONTROL_RESET); // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
            out_level_r <= 2'h0;
        end
        else if (access_c & PWRITE_I)
        begin
            if (hit1_c)
                ctl_r[0] <= pin_ctl_s'(PWDATA_I[15:0] & `PIN_CONTROL_WMASK);
            if (hit2_c)
                ctl_r[1] <= pin_ctl_s'(PWDATA_I[15:0] & `PIN_CONTROL_WMASK);
            if (hitl_c)
                out_level_r <= PWDATA_I[1:0];
        end
    end

    // ---------------- clock dividers ----------------
    logic [SLOW_W-1:0] slow_cnt_r;
    logic [FAST_W-1:0] fast_cnt_r;
    logic slow_tick_c;
    logic fast_tick_c;
    logic slow_clk_r;
    logic fast_clk_r;

    assign slow_tick_c = (slow_cnt_r == SLOW_W'(`OSC_SLOW_HALF_CYC - 1));
    assign fast_tick_c = (fast_cnt_r == FAST_W'(`EXT_CONV_HALF_CYC - 1));

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            slow_cnt_r <= '0;
            slow_clk_r <= 1'b0;
        end
        else if (slow_tick_c)
        begin
            slow_cnt_r <= '0;
            slow_clk_r <= ~slow_clk_r; // [R13]
        end
        else
            slow_cnt_r <= slow_cnt_r + SLOW_W'(1);
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            fast_cnt_r <= '0;
            fast_clk_r <= 1'b0;
        end
        else if (fast_tick_c)
        begin
            fast_cnt_r <= '0;
            fast_clk_r <= ~fast_clk_r; // [R18]
        end
        else
            fast_cnt_r <= fast_cnt_r + FAST_W'(1);
    end

    // ---------------- per-pin logic ----------------
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : pin
            pin_ctl_s ctl;
            logic is_input;
            logic long_deb;
            logic [CNT_W-1:0] limit;
            logic [CNT_W-1:0] cnt_r;
            logic src;

            assign ctl = ctl_r[g];
            assign is_input = ctl.direction; // [R1] [R20]
            // long variants filter longer
            assign long_deb = (ctl.function_select == IN_PLAIN_LONG) ||
                              (ctl.function_select == IN_SLEEP_WAKE_LONG) ||
                              (ctl.function_select == IN_HW_CONTROL1_LONG) ||
                              (ctl.function_select == IN_HW_CONTROL2_LONG);
            assign limit = long_deb ? CNT_W'(DEB_LONG_CYC) : CNT_W'(DEB_SHORT_CYC); // [R21] [R8]

            // new level accepted only after it held for the filter time
            always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    cnt_r <= '0;
                    deb_r[g] <= 1'b0;
                end
                else if (PIN_IN_I[g] == deb_r[g])
                    cnt_r <= '0;
                else if (cnt_r >= limit - CNT_W'(1))
                begin
                    cnt_r <= '0;
                    deb_r[g] <= PIN_IN_I[g]; // [R21]
                end
                else
                    cnt_r <= cnt_r + CNT_W'(1);
            end

            assign asserted_c[g] = ctl.polarity ? deb_r[g] : ~deb_r[g]; // [R5]
            // single mode: rising asserted level is rising pin if pol 1, falling if 0
            assign evt_c[g] = ctl.enable & is_input &
                              (ctl.edge_mode ? (asserted_c[g] != asserted_prev_r[g])
                                             : (asserted_c[g] & ~asserted_prev_r[g])); // [R3]

            always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                    asserted_prev_r[g] <= 1'b0;
                else
                    asserted_prev_r[g] <= asserted_c[g];
            end

            // one-hot input function hits, only for an enabled input
            always_comb
            begin
                in_hit[g] = 16'h0;
                if (ctl.enable & is_input) // [R7] [R20]
                    in_hit[g][ctl.function_select] = asserted_c[g]; // [R8] [R9] [R10] [R11] [R12]
            end

            always_comb
            begin
                unique case (out_fn_e'(ctl.function_select))
                    OUT_LEVEL: src = out_level_r[g]; // [R13]
                    OUT_OSC_SLOW: src = slow_clk_r; // [R13]
                    OUT_ON_STATE: src = ON_STATE_I; // [R14]
                    OUT_SLEEP_STATE: src = SLEEP_STATE_I; // [R14]
                    OUT_STATE_CHANGE: src = STATE_CHANGE_I; // [R14]
                    OUT_RSVD5, OUT_RSVD6, OUT_RSVD7: src = 1'b0; // [R14]
                    OUT_BUCK1_DONE: src = BUCK_DVS_DONE_I[0]; // [R15]
                    OUT_BUCK2_DONE: src = BUCK_DVS_DONE_I[1]; // [R15]
                    OUT_EXT_EN1: src = EXT_PWR_EN_I[0]; // [R16]
                    OUT_EXT_EN2: src = EXT_PWR_EN_I[1]; // [R16]
                    OUT_SUPPLY_GOOD: src = SYSTEM_SUPPLY_GOOD_I; // [R17]
                    OUT_POWER_GOOD: src = CONVERTER_POWER_GOOD_I; // [R17]
                    OUT_EXT_CLOCK: src = fast_clk_r; // [R18]
                    OUT_AUX_RESET: src = AUX_RESET_I; // [R19]
                endcase
            end

            // clocks are not inverted by polarity; level signals are
            assign drive_val_c[g] = (ctl.function_select == OUT_OSC_SLOW ||
                                     ctl.function_select == OUT_EXT_CLOCK) ? src
                                    : (ctl.polarity ? src : ~src); // [R5]
            // open drain only pulls low, releases for high
            assign drive_en_c[g] = ctl.enable & ~is_input &
                                   (~ctl.open_drain | ~drive_val_c[g]); // [R6] [R7] [R1]

            always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    PIN_OUT_O[g] <= 1'b0;
                    PIN_OE_N_O[g] <= 1'b1;
                    PIN_PULL_UP_O[g] <= 1'b0;
                    PIN_PULL_DOWN_O[g] <= 1'b1;
                    PIN_SUPPLY_AON_O[g] <= 1'b0;
                    PIN_EDGE_EVT_O[g] <= 1'b0;
                end
                else
                begin
                    PIN_OUT_O[g] <= drive_val_c[g] & ~ctl.open_drain; // [R6]
                    PIN_OE_N_O[g] <= ~drive_en_c[g]; // [R7]
                    PIN_PULL_UP_O[g] <= (ctl.pull_select == 2'h2); // [R2]
                    PIN_PULL_DOWN_O[g] <= (ctl.pull_select == 2'h1); // [R2]
                    PIN_SUPPLY_AON_O[g] <= ctl.supply_domain; // [R4]
                    PIN_EDGE_EVT_O[g] <= evt_c[g]; // [R3]
                end
            end
        end
    endgenerate

    // requests from either pin are or-ed together
    logic [15:0] any_hit_c;
    assign any_hit_c = in_hit[0] | in_hit[1];

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            POWER_TOGGLE_REQ_O <= 1'b0;
            SLEEP_WAKE_REQ_O <= 1'b0;
            SLEEP_REQ_O <= 1'b0;
            POWER_ON_REQ_O <= 1'b0;
            WATCHDOG_KICK_O <= 1'b0;
            VOLTAGE_SCALE_SELECT_O <= 2'h0;
            HW_ENABLE_O <= 2'h0;
            HW_CONTROL_O <= 2'h0;
        end
        else
        begin
            POWER_TOGGLE_REQ_O <= any_hit_c[IN_POWER_TOGGLE]; // [R9]
            SLEEP_WAKE_REQ_O <= any_hit_c[IN_SLEEP_WAKE] | any_hit_c[IN_SLEEP_WAKE_LONG]; // [R9]
            SLEEP_REQ_O <= any_hit_c[IN_SLEEP]; // [R9]
            POWER_ON_REQ_O <= any_hit_c[IN_POWER_ON]; // [R9]
            WATCHDOG_KICK_O <= any_hit_c[IN_WATCHDOG]; // [R10]
            VOLTAGE_SCALE_SELECT_O <= {any_hit_c[IN_VSCALE2], any_hit_c[IN_VSCALE1]}; // [R11]
            HW_ENABLE_O <= {any_hit_c[IN_HW_ENABLE2], any_hit_c[IN_HW_ENABLE1]}; // [R11]
            HW_CONTROL_O <= {any_hit_c[IN_HW_CONTROL2] | any_hit_c[IN_HW_CONTROL2_LONG],
                             any_hit_c[IN_HW_CONTROL1] | any_hit_c[IN_HW_CONTROL1_LONG]}; // [R12]
        end
    end

endmodule

/* src/pin_config_defs.svh */
// offsets, field positions, reset values and timing counts for the pin block
// assumes a 25 MHz system clock
`ifndef PIN_CONFIG_DEFS_SVH
`define PIN_CONFIG_DEFS_SVH

// register indices; byte address is four times the index
`define PIN1_CONTROL_IDX 16'h4038
`define PIN2_CONTROL_IDX 16'h4039
`define PIN_LEVEL_IDX 16'h403b

`define FLD_DIR 15
`define FLD_PULL_HI 14
`define FLD_PULL_LO 13
`define FLD_EDGE 12
`define FLD_DOMAIN 11
`define FLD_POL 10
`define FLD_OD 9
`define FLD_EN 7
`define FLD_FN_HI 3
`define FLD_FN_LO 0

`define PIN_CONTROL_RESET 16'ha400
`define PIN_CONTROL_WMASK 16'hfe8f

`define CLK_SYS_HZ 25000000
`define OSC_SLOW_HZ 32768
`define EXT_CONV_HZ 2000000
// half periods, rounded down
`define OSC_SLOW_HALF_CYC (`CLK_SYS_HZ / (2 * `OSC_SLOW_HZ))
`define EXT_CONV_HALF_CYC (`CLK_SYS_HZ / (2 * `EXT_CONV_HZ))

// filter times in microseconds
`define DEB_SHORT_US 1
`define DEB_LONG_US 2000
`define DEB_SHORT_CYC (`DEB_SHORT_US * (`CLK_SYS_HZ / 1000000))
`define DEB_LONG_CYC (`DEB_LONG_US * (`CLK_SYS_HZ / 1000000))

`endif

/* src/pin_config_pkg.sv */
// types for the pin configuration block
// assumes pin_config_defs.svh supplies the numbers
package pin_config_pkg;

    typedef struct packed {
        logic direction;
        logic [1:0] pull_select;
        logic edge_mode;
        logic supply_domain;
        logic polarity;
        logic open_drain;
        logic unused_8;
        logic enable;
        logic [2:0] unused_6_4;
        logic [3:0] function_select;
    } pin_ctl_s;

    typedef enum logic [3:0] {
        IN_PLAIN_LONG = 4'h0,
        IN_PLAIN = 4'h1,
        IN_POWER_TOGGLE = 4'h2,
        IN_SLEEP_WAKE = 4'h3,
        IN_SLEEP_WAKE_LONG = 4'h4,
        IN_SLEEP = 4'h5,
        IN_POWER_ON = 4'h6,
        IN_WATCHDOG = 4'h7,
        IN_VSCALE1 = 4'h8,
        IN_VSCALE2 = 4'h9,
        IN_HW_ENABLE1 = 4'ha,
        IN_HW_ENABLE2 = 4'hb,
        IN_HW_CONTROL1 = 4'hc,
        IN_HW_CONTROL2 = 4'hd,
        IN_HW_CONTROL1_LONG = 4'he,
        IN_HW_CONTROL2_LONG = 4'hf
    } in_fn_e;

    typedef enum logic [3:0] {
        OUT_LEVEL = 4'h0,
        OUT_OSC_SLOW = 4'h1,
        OUT_ON_STATE = 4'h2,
        OUT_SLEEP_STATE = 4'h3,
        OUT_STATE_CHANGE = 4'h4,
        OUT_RSVD5 = 4'h5,
        OUT_RSVD6 = 4'h6,
        OUT_RSVD7 = 4'h7,
        OUT_BUCK1_DONE = 4'h8,
        OUT_BUCK2_DONE = 4'h9,
        OUT_EXT_EN1 = 4'ha,
        OUT_EXT_EN2 = 4'hb,
        OUT_SUPPLY_GOOD = 4'hc,
        OUT_POWER_GOOD = 4'hd,
        OUT_EXT_CLOCK = 4'he,
        OUT_AUX_RESET = 4'hf
    } out_fn_e;

endpackage
